// *** pchc_defs.svh ***
// Constants for the palette and hardware cursor block.
// Assumes inclusion by its bare name from the design module and the bench.
`ifndef PCHC_DEFS_SVH
`define PCHC_DEFS_SVH

// Register byte offsets
`define PCHC_REG_CTRL 8'h00
`define PCHC_REG_AUXCTL 8'h04
`define PCHC_REG_CUR_HSTART 8'h08
`define PCHC_REG_CUR_VSTART 8'h0c
`define PCHC_REG_CUR_VEND 8'h10
`define PCHC_REG_BORDER 8'h14
`define PCHC_REG_CURCOL1 8'h18
`define PCHC_REG_CURCOL2 8'h1c
`define PCHC_REG_CURCOL3 8'h20
`define PCHC_REG_PAL_INDEX 8'h24
`define PCHC_REG_PAL_DATA 8'h28
`define PCHC_REG_STATUS 8'h2c

// Field positions
`define PCHC_CTRL_HIRES 3
`define PCHC_CTRL_INTERLACE 4
`define PCHC_AUX_LCD 13
`define PCHC_VS_PANEL_HI 14
`define PCHC_VS_PANEL_LO 13

// Sizes and codes
`define PCHC_CUR_WIDTH 12'h020
`define PCHC_CUR_WIDTH_HR 12'h010
`define PCHC_AUX_ENTRIES 8'h10
`define PCHC_BURST_LAST 2'h3
`define PCHC_PANEL_UPPER 2'h2
`define PCHC_PANEL_LOWER 2'h1
`define PCHC_PANEL_STRADDLE 2'h3

`endif

// *** pchc_pkg.sv ***
// Types shared by the palette and hardware cursor block.
// Assumes the constants header sits beside it.
package pchc_pkg;
    // Bits-per-pixel selection
    typedef enum logic [2:0] {
        BPP1 = 3'h0,
        BPP2 = 3'h1,
        BPP4 = 3'h2,
        BPP8 = 3'h3,
        BPP16 = 3'h4,
        BPP32 = 3'h5
    } pchc_bpp_t;

    // Cursor fetch states, one-hot
    typedef enum logic [1:0] {
        FS_IDLE = 2'b01,
        FS_REQ = 2'b10
    } pchc_fetch_t;
endpackage

// *** pchc_palette_cursor.sv ***
// Palette lookup, cursor fetch and cursor overlay in one pixel-clock module.
// Assumes video timing and the cursor memory port come from logic on clk_sys.
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/10ps
`include "pchc_defs.svh"

module pchc_palette_cursor (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Video timing
    input wire logic frame_start,
    input wire logic line_end,
    input wire logic field_odd,
    input wire logic vdisp,
    input wire logic hdisp,
    input wire logic [11:0] hcount,
    input wire logic [11:0] vcount,
    // Logical pixel stream
    input wire logic pix_valid,
    input wire logic [31:0] pix_data,
    // Cursor memory port
    output logic cur_req,
    input wire logic cur_wvalid,
    input wire logic [31:0] cur_wdata,
    // Physical pixel outputs
    output logic pix_out_valid,
    output logic [7:0] red_out,
    output logic [7:0] green_out,
    output logic [7:0] blue_table_output,
    output logic [7:0] aux_output_port,
    output logic flyback_indicator
);

    // Lookup tables
    logic [7:0] red_lut [0:255];
    logic [7:0] green_lut [0:255];
    logic [7:0] blue_lut [0:255];
    logic [3:0] aux_lut [0:15];

    // Control registers
    logic [4:0] ctrl_r;
    logic [31:0] auxctl_r;
    logic [11:0] hstart_r;
    logic [14:0] vstart_r;
    logic [11:0] vend_r;
    logic [27:0] border_r;
    logic [27:0] curcol_r [0:2];
    logic [7:0] pal_idx_r;
    logic [31:0] rdata_r;

    // Cursor state
    logic [31:0] cur_buf_r [0:3];
    logic [1:0] wcnt_r;
    pchc_pkg::pchc_fetch_t fstate_r;
    logic fetch_due_r;
    logic pair_r;
    logic row_had_cursor_r;
    logic [14:0] vs_act_r;
    logic [11:0] ve_act_r;
    logic flyback_r;

    // Output registers
    logic out_valid_r;
    logic [7:0] red_r;
    logic [7:0] green_r;
    logic [7:0] blue_r;
    logic [7:0] aux_r;

    // Mode decode
    wire pchc_pkg::pchc_bpp_t bpp = pchc_pkg::pchc_bpp_t'(ctrl_r[2:0]);
    wire hires = ctrl_r[`PCHC_CTRL_HIRES];
    wire interlace = ctrl_r[`PCHC_CTRL_INTERLACE];
    wire lcd = auxctl_r[`PCHC_AUX_LCD];
    wire [1:0] panel = vs_act_r[`PCHC_VS_PANEL_HI:`PCHC_VS_PANEL_LO];

    // Register decode
    wire sel_ctrl = reg_addr == `PCHC_REG_CTRL;
    wire sel_auxctl = reg_addr == `PCHC_REG_AUXCTL;
    wire sel_hstart = reg_addr == `PCHC_REG_CUR_HSTART;
    wire sel_vstart = reg_addr == `PCHC_REG_CUR_VSTART;
    wire sel_vend = reg_addr == `PCHC_REG_CUR_VEND;
    wire sel_border = reg_addr == `PCHC_REG_BORDER;
    wire sel_col1 = reg_addr == `PCHC_REG_CURCOL1;
    wire sel_col2 = reg_addr == `PCHC_REG_CURCOL2;
    wire sel_col3 = reg_addr == `PCHC_REG_CURCOL3;
    wire sel_pidx = reg_addr == `PCHC_REG_PAL_INDEX;
    wire sel_pdata = reg_addr == `PCHC_REG_PAL_DATA;
    wire sel_status = reg_addr == `PCHC_REG_STATUS;
    wire pal_wr = reg_wr && sel_pdata;
    wire pal_aux_hit = pal_idx_r < `PCHC_AUX_ENTRIES;

    // Palette entry as read back: aux, blue, green, red
    wire [3:0] pal_aux_rd = pal_aux_hit ? aux_lut[pal_idx_r[3:0]] : 4'h0;
    wire [27:0] pal_entry_rd = {pal_aux_rd, blue_lut[pal_idx_r], green_lut[pal_idx_r],
                                red_lut[pal_idx_r]};
    wire [31:0] status_word = {28'h0000000, cur_req, fetch_due_r, pair_r, flyback_r};

    // Read multiplexer, unmapped reads give zero
    wire [31:0] rd_mux =
        sel_ctrl ? {27'h0000000, ctrl_r} :
        sel_auxctl ? auxctl_r :
        sel_hstart ? {20'h00000, hstart_r} :
        sel_vstart ? {17'h00000, vstart_r} :
        sel_vend ? {20'h00000, vend_r} :
        sel_border ? {4'h0, border_r} :
        sel_col1 ? {4'h0, curcol_r[0]} :
        sel_col2 ? {4'h0, curcol_r[1]} :
        sel_col3 ? {4'h0, curcol_r[2]} :
        sel_pidx ? {24'h000000, pal_idx_r} :
        sel_pdata ? {4'h0, pal_entry_rd} :
        sel_status ? status_word : 32'h00000000;

    // Control register writes
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= 5'h00;
            auxctl_r <= 32'h00000000;
            hstart_r <= 12'h000;
            vstart_r <= 15'h0000;
            vend_r <= 12'h000;
            border_r <= 28'h0000000;
        end else if (reg_wr) begin
            if (sel_ctrl) ctrl_r <= reg_wdata[4:0];
            if (sel_auxctl) auxctl_r <= reg_wdata;
            if (sel_hstart) hstart_r <= reg_wdata[11:0];
            if (sel_vstart) vstart_r <= reg_wdata[14:0];
            if (sel_vend) vend_r <= reg_wdata[11:0];
            if (sel_border) border_r <= reg_wdata[27:0];
        end
    end

    // Cursor colours, one per opaque value
    genvar gc;
    generate
        for (gc = 0; gc < 3; gc++) begin : g_curcol
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    curcol_r[gc] <= 28'h0000000;
                end else if (reg_wr && reg_addr == `PCHC_REG_CURCOL1 + 8'(4 * gc)) begin
                    curcol_r[gc] <= reg_wdata[27:0];
                end
            end
        end
    endgenerate

    // Palette index auto-increments after each data write
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pal_idx_r <= 8'h00;
        end else if (reg_wr && sel_pidx) begin
            pal_idx_r <= reg_wdata[7:0];
        end else if (pal_wr) begin
            pal_idx_r <= pal_idx_r + 8'h01;
        end
    end

    // Table writes; aux entry exists only for the lowest sixteen indexes
    always_ff @(posedge clk_sys) begin
        if (pal_wr) begin
            red_lut[pal_idx_r] <= reg_wdata[7:0];
            green_lut[pal_idx_r] <= reg_wdata[15:8];
            blue_lut[pal_idx_r] <= reg_wdata[23:16];
            if (pal_aux_hit) aux_lut[pal_idx_r[3:0]] <= reg_wdata[27:24];
        end
    end

    // Read data stands the cycle after the strobe
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) rdata_r <= 32'h00000000;
        else if (reg_rd) rdata_r <= rd_mux;
        else rdata_r <= 32'h00000000;
    end
    assign reg_rdata = rdata_r;

    // Vertical limits take effect at frame starts, only even-field ones when interlaced
    wire take_limits = frame_start && (!interlace || !field_odd);
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            vs_act_r <= 15'h0000;
            ve_act_r <= 12'h000;
        end else if (take_limits) begin
            vs_act_r <= vstart_r;
            ve_act_r <= vend_r;
        end
    end

    // Vertical window of the cursor
    wire [11:0] vs_line = vs_act_r[11:0];
    wire in_range = vcount >= vs_line && vcount < ve_act_r;
    wire straddle = lcd && panel == `PCHC_PANEL_STRADDLE;
    wire strad_lower = vcount < vs_line;
    wire strad_upper = vcount >= ve_act_r;
    wire row_hit = straddle ? (strad_lower || strad_upper) : in_range;
    wire cursor_row = vdisp && row_hit;
    wire on_upper = straddle ? strad_upper : panel[1];
    wire on_lower = straddle ? strad_lower : panel[0];

    // Horizontal window, whole normal pixels only
    wire [11:0] cur_x = hcount - hstart_r;
    wire [11:0] cur_span = hires ? `PCHC_CUR_WIDTH_HR : `PCHC_CUR_WIDTH;
    wire in_cols = hcount >= hstart_r && cur_x < cur_span;

    // Cursor bits for this pixel
    wire [127:0] cur_bits = {cur_buf_r[3], cur_buf_r[2], cur_buf_r[1], cur_buf_r[0]};
    wire [6:0] nbit_idx = {pair_r, cur_x[4:0], 1'b0};
    wire [6:0] hbit_idx = {cur_x[3:0], 3'h0};
    wire cursor_here = cursor_row && in_cols;
    wire [1:0] cursor_pixel_bits = cursor_here ? cur_bits[nbit_idx +: 2] : 2'h0;
    wire [7:0] cursor_hr_bits = cursor_here ? cur_bits[hbit_idx +: 8] : 8'h00;

    // Cursor fetch sequencing
    wire burst_done = fstate_r == pchc_pkg::FS_REQ && cur_wvalid && wcnt_r == `PCHC_BURST_LAST;
    wire pair_done = hires || pair_r;
    wire start_fetch = line_end && (fetch_due_r || (row_had_cursor_r && pair_done));

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fetch_due_r <= 1'b0;
        end else if (frame_start) begin
            fetch_due_r <= 1'b1;
        end else if (line_end) begin
            fetch_due_r <= 1'b0;
        end
    end

    // Raster pairing and cursor presence on the current raster
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pair_r <= 1'b0;
            row_had_cursor_r <= 1'b0;
        end else if (frame_start) begin
            pair_r <= 1'b0;
            row_had_cursor_r <= 1'b0;
        end else if (line_end) begin
            if (row_had_cursor_r) pair_r <= hires ? 1'b0 : !pair_r;
            row_had_cursor_r <= 1'b0;
        end else if (cursor_row) begin
            row_had_cursor_r <= 1'b1;
        end
    end

    // Fetch state machine, four words per request
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fstate_r <= pchc_pkg::FS_IDLE;
            wcnt_r <= 2'h0;
        end else begin
            unique case (fstate_r)
                pchc_pkg::FS_IDLE: begin
                    wcnt_r <= 2'h0;
                    if (start_fetch) fstate_r <= pchc_pkg::FS_REQ;
                end
                pchc_pkg::FS_REQ: begin
                    if (cur_wvalid) wcnt_r <= wcnt_r + 2'h1;
                    if (burst_done) fstate_r <= pchc_pkg::FS_IDLE;
                end
            endcase
        end
    end
    assign cur_req = fstate_r == pchc_pkg::FS_REQ;

    // Cursor buffer takes the four words of each burst while the request stands
    always_ff @(posedge clk_sys) begin
        if (cur_req && cur_wvalid) cur_buf_r[wcnt_r] <= cur_wdata;
    end

    // Flyback follows the vertical display level
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) flyback_r <= 1'b1;
        else flyback_r <= !vdisp;
    end
    assign flyback_indicator = flyback_r;

    // Table index from logical pixel, narrow modes use low entries
    wire [7:0] idx_narrow =
        bpp == pchc_pkg::BPP1 ? {7'h00, pix_data[0]} :
        bpp == pchc_pkg::BPP2 ? {6'h00, pix_data[1:0]} :
        bpp == pchc_pkg::BPP4 ? {4'h0, pix_data[3:0]} : pix_data[7:0];
    wire wide = bpp == pchc_pkg::BPP32;
    wire [7:0] idx_r = wide ? pix_data[7:0] : idx_narrow;
    wire [7:0] idx_g = wide ? pix_data[15:8] : idx_narrow;
    wire [7:0] idx_b = wide ? pix_data[23:16] : idx_narrow;
    wire [3:0] idx_aux = wide ? pix_data[27:24] :
                         idx_narrow < `PCHC_AUX_ENTRIES ? idx_narrow[3:0] : 4'h0;

    // Underlying colour: video inside display, border elsewhere
    wire show_video = vdisp && hdisp;
    wire [27:0] video_col = {aux_lut[idx_aux], blue_lut[idx_b], green_lut[idx_g],
                             red_lut[idx_r]};
    wire [27:0] base_col = show_video ? video_col : border_r;
    wire [1:0] col_idx = cursor_pixel_bits == 2'h0 ? 2'h0 : cursor_pixel_bits - 2'h1;
    wire [27:0] cur_col = curcol_r[col_idx];
    wire use_cur_col = !hires && cursor_pixel_bits != 2'h0;
    wire [27:0] pix_col = use_cur_col && !lcd ? cur_col : base_col;

    // High-resolution overlay, one bit pair at a time
    wire [7:0] hr_out;
    genvar gp;
    generate
        for (gp = 0; gp < 4; gp++) begin : g_hrpair
            assign hr_out[2*gp +: 2] = cursor_hr_bits[2*gp] ?
                {2{cursor_hr_bits[2*gp+1]}} : base_col[16+2*gp +: 2];
        end
    endgenerate

    // LCD halves: cursor colour lands only on its own panel
    wire [3:0] lcd_upper = use_cur_col && on_upper ? cur_col[11:8] : base_col[11:8];
    wire [3:0] lcd_lower = use_cur_col && on_lower ? cur_col[27:24] : base_col[27:24];

    // Aux port routing by mode
    wire [7:0] aux_sel = hires ? hr_out :
                         lcd ? {lcd_upper, lcd_lower} :
                         {auxctl_r[7:4], pix_col[27:24]};

    // Output stage
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            out_valid_r <= 1'b0;
            red_r <= 8'h00;
            green_r <= 8'h00;
            blue_r <= 8'h00;
            aux_r <= 8'h00;
        end else begin
            out_valid_r <= pix_valid;
            if (pix_valid) begin
                red_r <= pix_col[7:0];
                green_r <= pix_col[15:8];
                blue_r <= pix_col[23:16];
                aux_r <= aux_sel;
            end
        end
    end
    assign pix_out_valid = out_valid_r;
    assign red_out = red_r;
    assign green_out = green_r;
    assign blue_table_output = blue_r;
    assign aux_output_port = aux_r;

    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    a_flyback_edge: assert property (vdisp ##1 !vdisp |=> flyback_indicator)
        else $error("flyback did not rise after display ended");

    a_fetch_start: assert property (fetch_due_r && line_end && !cur_req |=> cur_req)
        else $error("frame-start cursor fetch not issued");

    a_req_holds: assert property (cur_req && !burst_done |=> cur_req)
        else $error("cursor request dropped before four words");

    a_burst_ends: assert property (burst_done |=> !cur_req)
        else $error("cursor request not released after fourth word");

    a_aux_static: assert property (pix_valid && !hires && !lcd |=>
        aux_output_port[7:4] == $past(auxctl_r[7:4]))
        else $error("aux high nibble not from aux control");

    a_aux_8bpp: assert property (pix_valid && bpp == pchc_pkg::BPP8 && show_video
        && pix_data[7:4] != 4'h0 && !hires && !lcd && cursor_pixel_bits == 2'h0 |=>
        aux_output_port[3:0] == $past(aux_lut[0]))
        else $error("high 8bpp value did not read aux entry zero");

    a_vborder_plain: assert property (pix_valid && !vdisp && !lcd && !hires |=>
        {blue_table_output, green_out, red_out} == $past(border_r[23:0]))
        else $error("cursor or video shown in vertical border");

    a_cursor_color: assert property (pix_valid && !hires && !lcd
        && cursor_pixel_bits == 2'h2 |=> red_out == $past(curcol_r[1][7:0]))
        else $error("cursor value two not using its colour");

    a_hires_force: assert property (pix_valid && hires && cursor_hr_bits[0] |=>
        aux_output_port[1:0] == {2{$past(cursor_hr_bits[1])}})
        else $error("hires cursor pair did not force its high bit");

    a_cursor_width: assert property (cursor_pixel_bits != 2'h0 |-> cur_x < 12'h020)
        else $error("cursor outside its 32-pixel span");

endmodule

// *** pchc_mem_model.sv ***
// Memory controller model: answers each cursor fetch with a four-word burst.
// Assumes it shares clk_sys with the block and sees the fetch request directly.
`timescale 1ns/10ps

module pchc_mem_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Fetch handshake
    input wire logic cur_req,
    output logic cur_wvalid,
    output logic [31:0] cur_wdata,
    // Burst content and pacing from the bench
    input wire logic [127:0] burst,
    input wire logic [3:0] gap,
    output logic [7:0] served
);
    // Serve every request, frame-start one too; idle data is the inverse
    initial begin
        cur_wvalid = 1'b0;
        cur_wdata = 32'h0;
        served = 8'h00;
        forever begin
            @(posedge clk_sys);
            if (rst_n === 1'b1 && cur_req === 1'b1) begin
                served <= served + 8'h01;
                for (int w = 0; w < 4; w++) begin
                    if (gap != 4'h0) begin
                        cur_wvalid <= 1'b0;
                        cur_wdata <= ~cur_wdata;
                        repeat (gap) @(posedge clk_sys);
                    end
                    cur_wvalid <= 1'b1;
                    cur_wdata <= burst[w*32 +: 32];
                    @(posedge clk_sys);
                end
                cur_wvalid <= 1'b0;
                cur_wdata <= ~cur_wdata;
                @(posedge clk_sys);
            end
        end
    end
endmodule

// *** pchc_palette_cursor_tb.sv ***
// Bench for the palette and cursor block: registers, pixel path, fetch.
// Assumes the memory model and design files are compiled before it.
`timescale 1ns/10ps
`include "pchc_defs.svh"

module pchc_palette_cursor_tb;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic frame_start = 1'b0;
    logic line_end = 1'b0;
    logic field_odd = 1'b0;
    logic vdisp = 1'b0;
    logic hdisp = 1'b0;
    logic [11:0] hcount = 12'h000;
    logic [11:0] vcount = 12'h000;
    logic pix_valid = 1'b0;
    logic [31:0] pix_data = 32'h0;
    logic [3:0] gap = 4'h0;
    logic [127:0] burst = {32'h0, 32'h39, 32'h0, 32'h39};
    logic [31:0] reg_rdata, cur_wdata;
    logic cur_req, cur_wvalid, pix_out_valid, flyback_indicator;
    logic [7:0] red_out, green_out, blue_table_output, aux_output_port, served;
    int miscompares = 0;
    int comparisons = 0;

    // Clock at 100 MHz
    always #5 clk_sys = ~clk_sys;

    pchc_palette_cursor dut (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .frame_start, .line_end, .field_odd, .vdisp, .hdisp,
        .hcount, .vcount, .pix_valid, .pix_data, .cur_req, .cur_wvalid, .cur_wdata,
        .pix_out_valid, .red_out, .green_out, .blue_table_output, .aux_output_port,
        .flyback_indicator);
    pchc_mem_model mem (.clk_sys, .rst_n, .cur_req, .cur_wvalid, .cur_wdata,
        .burst, .gap, .served);

    // Palette entry pattern {aux, blue, green, red}
    function automatic logic [27:0] pe(input logic [7:0] n);
        pe = {n[3:0] ^ 4'h5, n ^ 8'h3c, n ^ 8'hc3, n};
    endfunction

    // High-res overlay: set low bit forces the pair to its high bit
    function automatic logic [7:0] hr(input logic [7:0] b, input logic [7:0] cd);
        hr = b;
        for (int i = 0; i < 8; i += 2) begin
            if (cd[i]) hr[i +: 2] = {2{cd[i+1]}};
        end
    endfunction

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_flag(input string what, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // One-cycle frame start or line end pulse
    task automatic pulse(input logic fs);
        @(posedge clk_sys);
        frame_start <= fs;
        line_end <= ~fs;
        @(posedge clk_sys);
        frame_start <= 1'b0;
        line_end <= 1'b0;
        #1;
    endtask

    task automatic wait_done;
        for (int i = 0; i < 40 && cur_req !== 1'b0; i++) @(posedge clk_sys);
        #1;
        check_flag("cur_req after burst", 1'b0, cur_req);
    endtask

    task automatic fetch;
        pulse(1'b1);
        pulse(1'b0);
        check_flag("cur_req at retrace", 1'b1, cur_req);
        wait_done();
    endtask

    task automatic pix(input logic [11:0] h, input logic [31:0] d);
        @(posedge clk_sys);
        pix_valid <= 1'b1;
        pix_data <= d;
        hcount <= h;
        @(posedge clk_sys);
        pix_valid <= 1'b0;
        #1;
    endtask

    task automatic check_px(input logic [27:0] e);
        check_flag("pix_out_valid", 1'b1, pix_out_valid);
        check("rgb", {8'h00, e[7:0], e[15:8], e[23:16]},
            {8'h00, red_out, green_out, blue_table_output});
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial begin
        repeat (5000) @(posedge clk_sys);
        miscompares++;
        report_and_stop();
    end

    // Test sequence
    initial begin
        logic [31:0] d;
        logic [27:0] e;
        logic [7:0] msk [4];
        logic [27:0] cc [4];
        msk = '{8'h01, 8'h03, 8'h0f, 8'hff};
        cc = '{28'h0111111, 28'h0222222, 28'h0333333, pe(8'h05)};
        repeat (3) @(posedge clk_sys);
        check_flag("flyback in reset", 1'b1, flyback_indicator);
        check("rdata in reset", 32'h0, reg_rdata);
        rst_n <= 1'b1;
        // Load palette during flyback
        wr(`PCHC_REG_AUXCTL, 32'h0000_00a0);
        wr(`PCHC_REG_PAL_INDEX, 32'h0);
        for (int n = 0; n < 32; n++) wr(`PCHC_REG_PAL_DATA, {4'h0, pe(8'(n))});
        wr(`PCHC_REG_PAL_INDEX, 32'h5);
        rd(`PCHC_REG_PAL_DATA, d);
        check("entry 5", {4'h0, pe(8'h05)}, d);
        rd(8'h30, d);
        check("unmapped", 32'h0, d);
        $display("test registers done");
        // Mapping per pixel depth
        @(posedge clk_sys);
        vdisp <= 1'b1;
        hdisp <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            wr(`PCHC_REG_CTRL, 32'(m));
            pix(12'h000, 32'h0000_001e);
            e = pe(msk[m] & 8'h1e);
            check_px(e);
            if (m == 3) e = pe(8'h00);
            check("aux", {24'h0, 4'ha, e[27:24]}, {24'h0, aux_output_port});
        end
        pix(12'h000, 32'h0000_0014);
        e = pe(8'h00);
        check("aux high index", {24'h0, 4'ha, e[27:24]}, {24'h0, aux_output_port});
        wr(`PCHC_REG_CTRL, 32'h5);
        pix(12'h000, 32'hf30a_0a0a);
        check_px(pe(8'h0a));
        e = pe(8'h03);
        check("aux 32bpp", {24'h0, 4'ha, e[27:24]}, {24'h0, aux_output_port});
        $display("test mapping done");
        // Cursor setup, frame-start fetch in flyback
        wr(`PCHC_REG_CTRL, 32'h3);
        wr(`PCHC_REG_CUR_HSTART, 32'h64);
        wr(`PCHC_REG_CUR_VSTART, 32'ha);
        wr(`PCHC_REG_CUR_VEND, 32'hc);
        wr(`PCHC_REG_BORDER, 32'h0445566);
        wr(`PCHC_REG_CURCOL1, 32'h0111111);
        wr(`PCHC_REG_CURCOL2, 32'h0222222);
        wr(`PCHC_REG_CURCOL3, 32'h0333333);
        @(posedge clk_sys);
        vdisp <= 1'b0;
        @(posedge clk_sys);
        #1;
        check_flag("flyback rise", 1'b1, flyback_indicator);
        fetch();
        @(posedge clk_sys);
        vdisp <= 1'b1;
        vcount <= 12'h00a;
        @(posedge clk_sys);
        #1;
        check_flag("flyback fall", 1'b0, flyback_indicator);
        // Cursor values over video
        for (int x = 0; x < 4; x++) begin
            pix(12'(12'h064 + x), 32'h0000_0005);
            check_px(cc[x]);
        end
        @(posedge clk_sys);
        hdisp <= 1'b0;
        pix(12'h064, 32'h5);
        check_px(28'h0111111);
        @(posedge clk_sys);
        vdisp <= 1'b0;
        pix(12'h064, 32'h5);
        check_px(28'h0445566);
        @(posedge clk_sys);
        vdisp <= 1'b1;
        hdisp <= 1'b1;
        pulse(1'b0);
        check_flag("no fetch mid pair", 1'b0, cur_req);
        @(posedge clk_sys);
        vcount <= 12'h00b;
        pulse(1'b0);
        check_flag("fetch after pair", 1'b1, cur_req);
        wait_done();
        $display("test cursor done");
        // High-res overlay with a slow memory
        wr(`PCHC_REG_CTRL, 32'hb);
        @(posedge clk_sys);
        gap <= 4'h2;
        vdisp <= 1'b0;
        fetch();
        @(posedge clk_sys);
        vdisp <= 1'b1;
        pix(12'h064, 32'h5);
        e = pe(8'h05);
        check("hires aux", {24'h0, hr(e[23:16], 8'h39)}, {24'h0, aux_output_port});
        pulse(1'b0);
        check_flag("hires fetch", 1'b1, cur_req);
        wait_done();
        check("bursts served", 32'h4, {24'h0, served});
        $display("test hires done");
        // LCD straddle, vertical limits held over an odd field
        wr(`PCHC_REG_CTRL, 32'h13);
        wr(`PCHC_REG_AUXCTL, 32'h20a0);
        wr(`PCHC_REG_CUR_VSTART, 32'h600a);
        wr(`PCHC_REG_CUR_VEND, 32'h1c);
        wr(`PCHC_REG_CURCOL1, 32'h9000300);
        for (int f = 1; f >= 0; f--) begin
            @(posedge clk_sys);
            field_odd <= f[0];
            vdisp <= 1'b0;
            fetch();
            @(posedge clk_sys);
            vdisp <= 1'b1;
            vcount <= 12'h005;
            pix(12'h064, 32'h5);
            check_px(pe(8'h05));
            check("lcd lower", f ? 32'h60 : 32'h69, {24'h0, aux_output_port});
        end
        @(posedge clk_sys);
        vcount <= 12'h020;
        pix(12'h064, 32'h5);
        check("lcd upper", 32'h30, {24'h0, aux_output_port});
        $display("test lcd done");
        report_and_stop();
    end
endmodule
